// >>> rtl/link_config_defines.vh
// Constants for the per-link control and static forwarding register bank
`ifndef LINK_CONFIG_DEFINES_VH
`define LINK_CONFIG_DEFINES_VH
`define NUM_LINKS 8
`define LINK_CTRL_BASE 8'h80
`define STATIC_BASE 8'ha0
`define LINK_PAGE 5'h10
`define STATIC_PAGE 5'h14
`define IRQ_STATUS_IDX 8'hb0
`define IRQ_ENABLE_IDX 8'hb1
`define IRQ_CLEAR_IDX 8'hb2
`define B_ENABLE 31
`define B_FIVE_WIRE 30
`define B_ERROR 27
`define B_ISSUED 26
`define B_HOLDS 25
`define B_CREDIT_RST 24
`define B_RX_RST 23
`define F_SYM_HI 21
`define F_SYM_LO 11
`define F_TOK_HI 10
`define F_TOK_LO 0
`define GAP_W 11
`define B_ST_EN 31
`define B_ST_CPU 8
`define F_CHAN_HI 4
`define F_CHAN_LO 0
`define IRQ_ERR_LO 0
`define IRQ_CREDIT_REQUEST_TOKEN_LO 8
`define ZERO32 32'h0000_0000
`define ZERO_GAP 11'h000
`endif

// >>> rtl/link_reg_mem.v
// Eight-word register memory with registered read data
`timescale 1ns/1ns
module link_reg_mem
(
  input wire clk_i,
  input wire rst_i,
  input wire we_i,
  input wire [2:0] waddr_i,
  input wire [31:0] wdata_i,
  input wire [2:0] raddr_i,
  output reg [31:0] rdata_o
);
  reg [31:0] mem_r [0:7];
  integer i;

  // Write port and registered read port
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (i = 0; i < 8; i = i + 1)
        mem_r[i] <= 32'h0000_0000;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      if (we_i)
        mem_r[waddr_i] <= wdata_i;
      rdata_o <= mem_r[raddr_i];
    end
  end
endmodule // link_reg_mem

// >>> rtl/link_config_static_forwarding.v
// Per-link control, status and static forwarding register bank on classic Wishbone
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ns
`include "link_config_defines.vh"
module link_config_static_forwarding
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire err_o,
  output wire irq_o,
  // Per-link status from the link transceivers, one bit per link
  input wire [7:0] rx_overflow_i,
  input wire [7:0] rx_illegal_i,
  input wire [7:0] credit_issued_set_i,
  input wire [7:0] credit_issued_clr_i,
  input wire [7:0] credit_got_i,
  input wire [7:0] credit_spent_i,
  // Per-link controls to the transceivers
  output reg [7:0] link_enable_o,
  output reg [7:0] pin_to_link_o,
  output reg [7:0] five_wire_o,
  output reg [7:0] credit_request_token_o,
  output reg [7:0] rx_reset_o,
  output reg [87:0] sym_gap_o,
  output reg [87:0] tok_gap_o,
  // Static forwarding, indexed by physical link 0..7 = A..H
  output reg [7:0] static_en_o,
  output reg [7:0] static_cpu_o,
  output reg [39:0] static_chan_o
);
  reg [7:0] enable_r;
  reg [7:0] five_r;
  reg [7:0] error_r;
  reg [7:0] issued_r;
  reg [7:0] holds_r;
  reg [`GAP_W-1:0] sym_r [0:7];
  reg [`GAP_W-1:0] tok_r [0:7];
  reg [15:0] irq_stat_r;
  reg [15:0] irq_en_r;
  reg [15:0] irq_stat_nxt;
  reg [7:0] error_nxt;
  reg [7:0] holds_nxt;
  reg [7:0] issued_nxt;
  reg [7:0] credit_request_token_nxt;
  reg [7:0] rxrst_nxt;
  reg [31:0] rd_nxt;
  reg sel_mux_r;
  reg [31:0] direct_r;
  wire [31:0] mem_rdata;
  wire req;
  wire wr_go;
  wire [2:0] idx;
  wire hit_link;
  wire hit_static;
  wire [31:0] wmask;
  wire [31:0] static_wdata;
  wire [2:0] phys_idx;
  wire static_we;
  reg [31:0] static_r [0:7];
  integer k;
  integer j;
  integer p;

  // Byte-lane mask from sel
  function [31:0] lane_mask;
    input [3:0] s;
    begin
      lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    end
  endfunction

  // Physical link (A=0..H=7) served by a static register index
  function [2:0] static_link;
    input [2:0] i;
    begin
      case (i)
        3'h0: static_link = 3'h2;
        3'h1: static_link = 3'h3;
        3'h2: static_link = 3'h0;
        3'h3: static_link = 3'h1;
        3'h4: static_link = 3'h6;
        3'h5: static_link = 3'h7;
        3'h6: static_link = 3'h4;
        default: static_link = 3'h5;
      endcase
    end
  endfunction

  // Keep only writable static fields
  function [31:0] static_clean;
    input [31:0] d;
    begin
      static_clean = `ZERO32;
      static_clean[`B_ST_EN] = d[`B_ST_EN];
      static_clean[`B_ST_CPU] = d[`B_ST_CPU];
      static_clean[`F_CHAN_HI:`F_CHAN_LO] = d[`F_CHAN_HI:`F_CHAN_LO];
    end
  endfunction

  // Bus decode; one-cycle answer, ack drops next cycle
  assign req = cyc_i & stb_i & ~ack_o;
  assign idx = adr_i[2:0];
  assign hit_link = (adr_i[7:3] == `LINK_PAGE);
  assign hit_static = (adr_i[7:3] == `STATIC_PAGE);
  assign wr_go = req & we_i;
  assign wmask = lane_mask(sel_i);
  assign err_o = 1'b0;
  assign irq_o = |(irq_stat_r & irq_en_r);

  // Static word merged per byte lane and cleaned; the memory mirrors static_r for the bus read path
  assign phys_idx = static_link(idx);
  assign static_we = wr_go & hit_static;
  assign static_wdata = static_clean((static_r[phys_idx] & ~wmask) | (dat_i & wmask));

  link_reg_mem static_mem
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(static_we),
    .waddr_i(phys_idx),
    .wdata_i(static_wdata),
    .raddr_i(phys_idx),
    .rdata_o(mem_rdata)
  );

  // Link status update: hardware sets win over clears
  always @*
  begin
    error_nxt = error_r | rx_overflow_i | rx_illegal_i;
    holds_nxt = (holds_r & ~credit_spent_i) | credit_got_i;
    issued_nxt = (issued_r & ~credit_issued_clr_i) | credit_issued_set_i;
    credit_request_token_nxt = 8'h00;
    rxrst_nxt = 8'h00;
    if (wr_go && hit_link)
    begin
      if (sel_i[3] && dat_i[`B_CREDIT_RST])
      begin
        holds_nxt[idx] = credit_got_i[idx]; // Credit arriving in the same cycle wins
        credit_request_token_nxt[idx] = 1'b1;
      end
      if (sel_i[2] && dat_i[`B_RX_RST])
      begin
        rxrst_nxt[idx] = 1'b1;
        error_nxt[idx] = rx_overflow_i[idx] | rx_illegal_i[idx];
      end
    end
    irq_stat_nxt = irq_stat_r;
    if (wr_go && adr_i == `IRQ_CLEAR_IDX)
      irq_stat_nxt = irq_stat_r & ~dat_i[15:0];
    irq_stat_nxt = irq_stat_nxt | {credit_request_token_nxt, rx_overflow_i | rx_illegal_i};
  end

  // Read data assembly for direct registers
  always @*
  begin
    rd_nxt = `ZERO32;
    if (hit_link)
    begin
      rd_nxt[`B_ENABLE] = enable_r[idx];
      rd_nxt[`B_FIVE_WIRE] = five_r[idx];
      rd_nxt[`B_ERROR] = error_r[idx];
      rd_nxt[`B_ISSUED] = issued_r[idx];
      rd_nxt[`B_HOLDS] = holds_r[idx];
      rd_nxt[`F_SYM_HI:`F_SYM_LO] = sym_r[idx];
      rd_nxt[`F_TOK_HI:`F_TOK_LO] = tok_r[idx];
    end
    else if (adr_i == `IRQ_STATUS_IDX)
      rd_nxt[15:0] = irq_stat_r;
    else if (adr_i == `IRQ_ENABLE_IDX)
      rd_nxt[15:0] = irq_en_r;
  end

  // Registers and bus response
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      enable_r <= 8'h00;
      five_r <= 8'h00;
      error_r <= 8'h00;
      issued_r <= 8'h00;
      holds_r <= 8'h00;
      for (k = 0; k < `NUM_LINKS; k = k + 1)
      begin
        sym_r[k] <= `ZERO_GAP;
        tok_r[k] <= `ZERO_GAP;
      end
      irq_stat_r <= 16'h0000;
      irq_en_r <= 16'h0000;
      ack_o <= 1'b0;
      direct_r <= `ZERO32;
      credit_request_token_o <= 8'h00;
      rx_reset_o <= 8'h00;
    end
    else
    begin
      ack_o <= req;
      direct_r <= rd_nxt;
      error_r <= error_nxt;
      holds_r <= holds_nxt;
      issued_r <= issued_nxt;
      irq_stat_r <= irq_stat_nxt;
      credit_request_token_o <= credit_request_token_nxt;
      rx_reset_o <= rxrst_nxt;
      if (wr_go && hit_link)
      begin
        if (sel_i[3])
        begin
          enable_r[idx] <= dat_i[`B_ENABLE];
          five_r[idx] <= dat_i[`B_FIVE_WIRE];
        end
        sym_r[idx] <= (sym_r[idx] & ~wmask[`F_SYM_HI:`F_SYM_LO]) |
                      (dat_i[`F_SYM_HI:`F_SYM_LO] & wmask[`F_SYM_HI:`F_SYM_LO]);
        tok_r[idx] <= (tok_r[idx] & ~wmask[`F_TOK_HI:`F_TOK_LO]) |
                      (dat_i[`F_TOK_HI:`F_TOK_LO] & wmask[`F_TOK_HI:`F_TOK_LO]);
      end
      if (wr_go && adr_i == `IRQ_ENABLE_IDX)
        irq_en_r <= (irq_en_r & ~wmask[15:0]) | (dat_i[15:0] & wmask[15:0]);
    end
  end

  // Static forwarding registers, stored by physical link
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (j = 0; j < `NUM_LINKS; j = j + 1)
        static_r[j] <= `ZERO32;
      sel_mux_r <= 1'b0;
    end
    else
    begin
      sel_mux_r <= hit_static;
      if (static_we)
        static_r[phys_idx] <= static_wdata;
    end
  end

  // Bus read data mux: static words come from the memory's read register
  always @*
  begin
    if (sel_mux_r)
      dat_o = mem_rdata;
    else
      dat_o = direct_r;
  end

  // Drive link-side controls from the registers
  always @*
  begin
    for (p = 0; p < `NUM_LINKS; p = p + 1)
    begin
      link_enable_o[p] = enable_r[p];
      pin_to_link_o[p] = enable_r[p];
      five_wire_o[p] = five_r[p];
      sym_gap_o[p*`GAP_W +: `GAP_W] = sym_r[p];
      tok_gap_o[p*`GAP_W +: `GAP_W] = tok_r[p];
      static_en_o[p] = static_r[p][`B_ST_EN];
      static_cpu_o[p] = static_r[p][`B_ST_CPU];
      static_chan_o[p*5 +: 5] = static_r[p][`F_CHAN_HI:`F_CHAN_LO];
    end
  end
endmodule // link_config_static_forwarding

// >>> bench/link_far_end.sv
// Far-end model of the token link transceivers
`timescale 1ns/1ns
module link_far_end
(
  input wire clk_i,
  input wire rst_i,
  input wire [7:0] bad_tok_i,
  input wire [7:0] credit_request_token_i,
  output reg [7:0] rx_illegal_o,
  output reg [7:0] credit_got_o
);
  // Grants credit a cycle after a request, flags bad tokens
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rx_illegal_o <= 8'h00;
      credit_got_o <= 8'h00;
    end
    else
    begin
      rx_illegal_o <= bad_tok_i;
      credit_got_o <= credit_request_token_i;
    end
  end
endmodule // link_far_end

// >>> bench/link_cfg_monitor.sv
// Bus and control checker for the link register bank
`timescale 1ns/1ns
module link_cfg_monitor
(
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire err_o,
  input wire [7:0] link_enable_o,
  input wire [7:0] pin_to_link_o,
  input wire [7:0] five_wire_o,
  input wire [7:0] credit_request_token_o,
  input wire [7:0] rx_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Request taken, and top-lane write to a link word
  sequence req_s;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence wr_top_s;
    req_s ##0 we_i && adr_i[7:3] == 5'h10 && sel_i[3];
  endsequence
  ack_lat_a: assert property (req_s |=> ack_o) else $error("ack late");
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack long");
  no_err_a: assert property (!err_o) else $error("err raised");
  pin_mux_a: assert property (pin_to_link_o == link_enable_o) else $error("pin mux");
  en_wr_a: assert property (wr_top_s |=> link_enable_o[$past(adr_i[2:0])] == $past(dat_i[31]))
    else $error("enable");
  wire_wr_a: assert property (wr_top_s |=> five_wire_o[$past(adr_i[2:0])] == $past(dat_i[30]))
    else $error("wires");
  tok_pulse_a: assert property (wr_top_s ##0 dat_i[24] |=> credit_request_token_o[$past(adr_i[2:0])]
    ##1 credit_request_token_o == 8'h00) else $error("token");
  rx_pulse_a: assert property (req_s ##0 we_i && adr_i[7:3] == 5'h10 && sel_i[2] && dat_i[23]
    |=> rx_reset_o[$past(adr_i[2:0])] ##1 rx_reset_o == 8'h00) else $error("rx reset");
  unmap_rd_a: assert property (req_s ##0 !we_i && !adr_i[7] |=> dat_o == 32'h0000_0000)
    else $error("unmapped");
endmodule // link_cfg_monitor
bind link_config_static_forwarding link_cfg_monitor mon (.*);

// >>> bench/test_link_config_static_forwarding.sv
// Self-checking bench for the link register bank
`timescale 1ns/1ns
module test_link_config_static_forwarding;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg cyc_i = 1'b0;
  reg stb_i = 1'b0;
  reg we_i = 1'b0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'h0;
  reg [31:0] dat_i = 32'h0;
  reg [7:0] bad = 8'h00;
  reg [7:0] ovf = 8'h00;
  reg [7:0] iss_set = 8'h00;
  reg [7:0] iss_clr = 8'h00;
  reg [7:0] spent = 8'h00;
  reg [31:0] rd;
  reg [7:0] tk;
  reg [7:0] rr;
  reg [75:0] rows [0:4];
  reg [23:0] phys = {3'd5, 3'd4, 3'd7, 3'd6, 3'd1, 3'd0, 3'd3, 3'd2};
  wire [31:0] dat_o;
  wire ack_o;
  wire irq_o;
  wire [7:0] ill, got, en, fw, tok, rxr, sen, scpu;
  wire [87:0] sg, tg;
  wire [39:0] sch;
  integer num_errors = 0;
  integer checks = 0;
  integer i;
  always #5 clk_i = ~clk_i;
  link_far_end far (.clk_i(clk_i), .rst_i(rst_i), .bad_tok_i(bad), .credit_request_token_i(tok),
    .rx_illegal_o(ill), .credit_got_o(got));
  link_config_static_forwarding DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(), .irq_o(irq_o), .rx_overflow_i(ovf), .rx_illegal_i(ill), .credit_issued_set_i(iss_set),
    .credit_issued_clr_i(iss_clr), .credit_got_i(got), .credit_spent_i(spent), .link_enable_o(en),
    .pin_to_link_o(), .five_wire_o(fw), .credit_request_token_o(tok), .rx_reset_o(rxr),
    .sym_gap_o(sg), .tok_gap_o(tg), .static_en_o(sen), .static_cpu_o(scpu), .static_chan_o(sch));
  // Compare and report
  task check(input [63:0] nm, input [31:0] seen, input [31:0] exp);
  begin
    checks = checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // One classic Wishbone cycle, started just after an edge
  task wb(input w, input [7:0] a, input [31:0] d, input [3:0] s);
    integer n;
  begin
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    n = 0;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 20)
    begin
      @(posedge clk_i);
      n = n + 1;
    end
    check("ack", ack_o, 1'b1);
    if (n == 20)
      end_of_test;
    rd = dat_o;
    tk = tok;
    rr = rxr;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  end
  endtask
  // Pulse a bad token on link zero
  task inject;
  begin
    bad <= 8'h01;
    @(posedge clk_i);
    bad <= 8'h00;
    repeat (3) @(posedge clk_i);
  end
  endtask
  // Main sequence
  initial
  begin
    rows[0] = {8'h80, 32'hc000_0000, 4'hf, 32'hc000_0000};
    rows[1] = {8'h87, 32'h3fff_ffff, 4'hf, 32'h023f_ffff};
    rows[2] = {8'ha0, 32'hffff_ffff, 4'hf, 32'h8000_011f};
    rows[3] = {8'h40, 32'hffff_ffff, 4'hf, 32'h0000_0000};
    rows[4] = {8'h81, 32'hc000_0000, 4'h7, 32'h0000_0000};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'h80, 0, 4'hf);
    check("rst80", rd, 32'h0);
    wb(0, 8'ha0, 0, 4'hf);
    check("rsta0", rd, 32'h0);
    for (i = 0; i < 5; i = i + 1)
    begin
      wb(1, rows[i][75:68], rows[i][67:36], rows[i][35:32]);
      wb(0, rows[i][75:68], 0, 4'hf);
      check("row", rd, rows[i][31:0]);
    end
    check("lnk", {en, fw}, 16'h0101);
    check("gap", {sg[87:77], tg[87:77]}, 22'h3f_ffff);
    check("stc", {sen, scpu, sch[14:10]}, 21'h00_809f);
    wb(1, 8'h80, 32'h0100_0000, 4'h8);
    check("tok", {tk, en}, 16'h0100);
    wb(0, 8'h80, 0, 4'hf);
    check("held", rd, 32'h0200_0000);
    for (i = 0; i < 8; i = i + 1)
    begin
      wb(1, 8'ha0 + i, i, 4'hf);
      check("chan", sch[phys[i*3+:3]*5+:5], i);
    end
    inject;
    check("mask", irq_o, 1'b0);
    wb(0, 8'hb0, 0, 4'hf);
    check("stat", rd, 32'h0000_8101);
    wb(1, 8'hb1, 1, 4'hf);
    check("irq", irq_o, 1'b1);
    wb(0, 8'h80, 0, 4'hf);
    check("errb", rd[27], 1'b1);
    wb(1, 8'hb2, 1, 4'hf);
    check("clr", irq_o, 1'b0);
    wb(1, 8'h80, 32'h0080_0000, 4'h4);
    check("rxr", rr, 8'h01);
    wb(0, 8'h80, 0, 4'hf);
    check("errc", rd[27], 1'b0);
    // Overflow and issued credit on link one, then credit spent on link zero and issue withdrawn on link one
    ovf <= 8'h02;
    iss_set <= 8'h02;
    @(posedge clk_i);
    ovf <= 8'h00;
    iss_set <= 8'h00;
    @(posedge clk_i);
    wb(0, 8'h81, 0, 4'hf);
    check("iss", rd, 32'h0c00_0000);
    spent <= 8'h01;
    iss_clr <= 8'h02;
    @(posedge clk_i);
    spent <= 8'h00;
    iss_clr <= 8'h00;
    @(posedge clk_i);
    wb(0, 8'h81, 0, 4'hf);
    check("isclr", rd, 32'h0800_0000);
    wb(0, 8'h80, 0, 4'hf);
    check("spent", rd, 32'h0);
    // Second reset in mid-run clears sticky and stored state
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, 8'h81, 0, 4'hf);
    check("rst81", rd, 32'h0);
    wb(0, 8'ha2, 0, 4'hf);
    check("rsta2", rd, 32'h0);
    wb(0, 8'hb0, 0, 4'hf);
    check("rstb0", rd, 32'h0);
    end_of_test;
  end
endmodule // test_link_config_static_forwarding
